// *** rtl/nce_core.sv ***
// nibble cpu instruction executor with apb status and control
//
// Our own choices: the placing of the registers and register access over APB.
`timescale 1ns/100ps
module nce_core
   import nce_pkg::*;
(
   input wire logic i_mclk,
   input wire logic i_srst,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [7:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   output logic o_pready,
   output logic [31:0] o_prdata,
   output logic o_pslverr,
   output logic [nce_pkg::NCE_PC_W-1:0] o_pm_addr,
   input wire logic [9:0] i_pm_data,
   output logic [9:0] o_dm_addr,
   input wire logic [3:0] i_dm_rdata,
   output logic [3:0] o_dm_wdata,
   output logic o_dm_we,
   input wire logic [3:0] i_p0,
   input wire logic [3:0] i_p1,
   input wire logic [3:0] i_p2,
   output logic [3:0] o_p0,
   output logic [3:0] o_p1,
   output logic [3:0] o_p2,
   output logic [7:0] o_port_d,
   output logic o_irq_enable,
   output logic o_rc_clock_sel,
   output logic o_wdt_stop_armed,
   output logic o_clock_mode,
   output logic o_ram_backup
);
   import nce_pkg::*;

   nce_state_type state_q;
   logic [NCE_PC_W-1:0] pc_q;
   logic [NCE_PC_W-1:0] stack_q [NCE_STACK_DEPTH];
   logic [2:0] stack_ptr_q;
   logic [9:0] word1_q;
   logic skip_q, skip2_q;
   logic last_acc_ld_q, last_xy_ld_q;
   logic unlock_q, ie_pend_q;
   logic [3:0] acc_q, x_q, y_q;
   logic [1:0] z_q;
   logic carry_q;
   logic run_q, wake_q;
   logic [2:0] dreg_q;
   logic [11:0] p_s1_q, p_s2_q, p_s3_q, p_val_q;
   logic [3:0] y_inc, y_dec;
   nce_status_type status;

   // decode of the word in the execute cycle
   logic [9:0] w;
   logic is_acc_ld, is_xy_ld, is_call1, do_op;
   assign w = i_pm_data;
   assign is_acc_ld = (w[9:4] == NCE_OP_ACC_LOAD_HI);
   assign is_xy_ld = (w[9:8] == NCE_OP_XY_LOAD_HI);
   assign is_call1 = (w[9:5] == NCE_OP_LONG_DIRECT_CALL_HI) ||
                     (w == NCE_OP_LONG_INDEXED_CALL);
   assign do_op = (state_q == NCE_ST_EXEC) && !skip_q &&
                  !(is_acc_ld && last_acc_ld_q) &&
                  !(is_xy_ld && last_xy_ld_q);
   assign y_inc = y_q + 4'h1;
   assign y_dec = y_q - 4'h1;

   // three-stage input synchroniser, value taken when stages 2 and 3 agree
   always_ff @(posedge i_mclk)
   begin
      if (i_srst)
      begin
         p_s1_q <= 12'h000;
         p_s2_q <= 12'h000;
         p_s3_q <= 12'h000;
         p_val_q <= 12'h000;
      end
      else
      begin
         p_s1_q <= {i_p2, i_p1, i_p0};
         p_s2_q <= p_s1_q;
         p_s3_q <= p_s2_q;
         p_val_q <= (p_s2_q & ~(p_s2_q ^ p_s3_q)) |
                    (p_val_q & (p_s2_q ^ p_s3_q));
      end
   end

   // sequencing, fetch and skip bookkeeping
   always_ff @(posedge i_mclk)
   begin
      if (i_srst)
      begin
         state_q <= NCE_ST_FETCH;
         pc_q <= NCE_PC_RST;
         o_pm_addr <= NCE_PC_RST;
         word1_q <= NCE_OP_NOP;
         skip_q <= 1'b0;
         skip2_q <= 1'b0;
         last_acc_ld_q <= 1'b0;
         last_xy_ld_q <= 1'b0;
         unlock_q <= 1'b0;
      end
      else
      begin
         unique case (state_q)
            NCE_ST_FETCH, NCE_ST_FETCH2:
            begin
               if (run_q)
               begin
                  o_pm_addr <= pc_q;
                  pc_q <= pc_q + 13'h0001;
                  state_q <= (state_q == NCE_ST_FETCH) ? NCE_ST_EXEC
                                                       : NCE_ST_EXEC2;
               end
            end
            NCE_ST_EXEC:
            begin
               word1_q <= w;
               skip_q <= 1'b0;
               skip2_q <= skip_q;
               last_acc_ld_q <= is_acc_ld;
               last_xy_ld_q <= is_xy_ld;
               // unlock lives for exactly one following instruction
               unlock_q <= do_op && (w == NCE_OP_POWERDOWN_UNLOCK);
               if (is_call1)
                  state_q <= NCE_ST_FETCH2;
               else if (do_op && unlock_q &&
                        (w == NCE_OP_CLOCK_MODE_ENTRY ||
                         w == NCE_OP_RAM_BACKUP_ENTRY))
                  state_q <= NCE_ST_HALT;
               else
                  state_q <= NCE_ST_FETCH;
               if (do_op && w == NCE_OP_Y_INCREMENT_SKIP)
                  skip_q <= (y_inc == 4'h0);
               if (do_op && w == NCE_OP_Y_DECREMENT_SKIP)
                  skip_q <= (y_dec == NCE_Y_MAX);
            end
            NCE_ST_EXEC2:
            begin
               state_q <= NCE_ST_FETCH;
               if (!skip2_q)
               begin
                  if (word1_q == NCE_OP_LONG_INDEXED_CALL)
                     pc_q <= {w[7], w[6], w[3:0], dreg_q, acc_q};
                  else
                     pc_q <= {w[7], word1_q[4:0], w[6:0]};
               end
            end
            NCE_ST_HALT:
            begin
               if (wake_q)
                  state_q <= NCE_ST_FETCH;
            end
            default:
               state_q <= NCE_ST_FETCH;
         endcase
      end
   end

   // return stack; wraps silently past eight levels
   always_ff @(posedge i_mclk)
   begin
      if (i_srst)
      begin
         stack_ptr_q <= 3'h0;
         for (int i = 0; i < NCE_STACK_DEPTH; i++)
            stack_q[i] <= NCE_PC_RST;
      end
      else if (state_q == NCE_ST_EXEC2 && !skip2_q)
      begin
         stack_ptr_q <= stack_ptr_q + 3'h1;
         stack_q[stack_ptr_q + 3'h1] <= pc_q;
      end
   end

   // accumulator, carry and data pointer
   always_ff @(posedge i_mclk)
   begin
      if (i_srst)
      begin
         acc_q <= NCE_NIB_RST;
         carry_q <= 1'b0;
         x_q <= NCE_NIB_RST;
         y_q <= NCE_NIB_RST;
         z_q <= 2'h0;
      end
      else if (do_op)
      begin
         if (w == NCE_OP_ACC_INVERT)
            acc_q <= ~acc_q;
         if (w == NCE_OP_LOGIC_OR)
            acc_q <= acc_q | i_dm_rdata;
         if (w == NCE_OP_ACC_ROTATE_RIGHT)
            {acc_q, carry_q} <= {carry_q, acc_q};
         if (w[9:2] == NCE_OP_PORT_READ_HI && w[1:0] != 2'h3)
            acc_q <= p_val_q[{w[1:0], 2'h0} +: 4];
         if (is_acc_ld)
            acc_q <= w[3:0];
         if (is_xy_ld)
         begin
            x_q <= w[7:4];
            y_q <= w[3:0];
         end
         if (w[9:2] == NCE_OP_Z_LOAD_HI)
            z_q <= w[1:0];
         if (w == NCE_OP_Y_INCREMENT_SKIP)
            y_q <= y_inc;
         if (w == NCE_OP_Y_DECREMENT_SKIP)
            y_q <= y_dec;
      end
   end

   // memory bit clear, written in the cycle after decode
   always_ff @(posedge i_mclk)
   begin
      if (i_srst)
      begin
         o_dm_we <= 1'b0;
         o_dm_wdata <= NCE_NIB_RST;
      end
      else
      begin
         o_dm_we <= do_op && (w[9:2] == NCE_OP_BIT_CLEAR_HI);
         o_dm_wdata <= i_dm_rdata & ~(4'h1 << w[1:0]);
      end
   end
   assign o_dm_addr = {z_q, x_q, y_q};

   // ports and mode flags
   always_ff @(posedge i_mclk)
   begin
      if (i_srst)
      begin
         o_p0 <= NCE_NIB_RST;
         o_p1 <= NCE_NIB_RST;
         o_p2 <= NCE_NIB_RST;
         o_port_d <= NCE_PORTD_RST;
         o_rc_clock_sel <= 1'b0;
         o_wdt_stop_armed <= 1'b0;
         o_clock_mode <= 1'b0;
         o_ram_backup <= 1'b0;
      end
      else
      begin
         if (do_op && w == NCE_OP_PORTD_SET)
            o_port_d <= NCE_PORTD_ONES;
         if (do_op && w == NCE_OP_RC_CLOCK_SELECT)
            o_rc_clock_sel <= 1'b1;
         if (do_op && w == NCE_OP_WATCHDOG_STOP_ARM)
            o_wdt_stop_armed <= 1'b1;
         if (do_op && w[9:2] == NCE_OP_PORT_WRITE_HI)
         begin
            if (w[1:0] == 2'h0)
               o_p0 <= acc_q;
            if (w[1:0] == 2'h1)
               o_p1 <= acc_q;
            if (w[1:0] == 2'h2)
               o_p2 <= acc_q;
         end
         if (wake_q)
         begin
            o_clock_mode <= 1'b0;
            o_ram_backup <= 1'b0;
         end
         // entry beats a same-cycle wake, so mode and halt agree
         if (do_op && unlock_q)
         begin
            if (w == NCE_OP_CLOCK_MODE_ENTRY)
               o_clock_mode <= 1'b1;
            if (w == NCE_OP_RAM_BACKUP_ENTRY)
               o_ram_backup <= 1'b1;
         end
      end
   end

   // interrupt enable: pending stage gives the one-instruction delay
   always_ff @(posedge i_mclk)
   begin
      if (i_srst)
      begin
         ie_pend_q <= 1'b0;
         o_irq_enable <= 1'b0;
      end
      else if (do_op && w == NCE_OP_IRQ_DISABLE)
      begin
         ie_pend_q <= 1'b0;
         o_irq_enable <= 1'b0;
      end
      else if (state_q == NCE_ST_EXEC)
      begin
         ie_pend_q <= do_op && (w == NCE_OP_IRQ_ENABLE);
         if (ie_pend_q)
            o_irq_enable <= 1'b1;
      end
   end

   // apb slave, one wait state so all outputs come from flops
   assign status = '{o_ram_backup, o_clock_mode, o_rc_clock_sel,
                     o_wdt_stop_armed, o_irq_enable, carry_q, stack_ptr_q, z_q,
                     y_q, x_q, acc_q};
   always_ff @(posedge i_mclk)
   begin
      if (i_srst)
      begin
         o_pready <= 1'b0;
         o_prdata <= 32'h00000000;
         o_pslverr <= 1'b0;
         run_q <= 1'b0;
         wake_q <= 1'b0;
         dreg_q <= 3'h0;
      end
      else
      begin
         wake_q <= 1'b0;
         o_pready <= i_psel && i_penable && !o_pready;
         o_pslverr <= 1'b0;
         o_prdata <= 32'h00000000;
         if (i_psel && i_penable && !o_pready)
         begin
            unique case (i_paddr)
               NCE_OFS_CTRL:
               begin
                  o_prdata <= {25'h0000000, dreg_q, 3'h0, run_q};
                  if (i_pwrite)
                  begin
                     run_q <= i_pwdata[NCE_CTRL_RUN];
                     wake_q <= i_pwdata[NCE_CTRL_WAKE];
                     dreg_q <= i_pwdata[NCE_CTRL_DR_LSB +: 3];
                  end
               end
               NCE_OFS_STATUS:
                  o_prdata <= {9'h000, status};
               NCE_OFS_PC:
                  o_prdata <= {19'h00000, pc_q};
               default:
                  o_pslverr <= 1'b1;
            endcase
         end
      end
   end

   sequence s_irq_en_taken;
      do_op && w == NCE_OP_IRQ_ENABLE;
   endsequence
   sequence s_next_exec;
      (state_q != NCE_ST_EXEC) [*1] ##1 state_q == NCE_ST_EXEC;
   endsequence

   a_irq_en_delayed: assert property (@(posedge i_mclk) disable iff (i_srst)
      s_irq_en_taken ##1 (!o_irq_enable && ie_pend_q) ##0 s_next_exec
      |=> o_irq_enable || $past(do_op && w == NCE_OP_IRQ_DISABLE))
      else $error("irq enable not set one instruction after enable");
   // a pending enable from an earlier one may land on this edge
   a_irq_en_not_early: assert property (@(posedge i_mclk) disable iff (i_srst)
      (s_irq_en_taken and (!o_irq_enable && !ie_pend_q)) |=> !o_irq_enable)
      else $error("irq enable took effect too early");
   a_irq_dis_clears: assert property (@(posedge i_mclk) disable iff (i_srst)
      do_op && w == NCE_OP_IRQ_DISABLE |=> !o_irq_enable && !ie_pend_q)
      else $error("irq disable did not clear enable");
   a_invert_acc: assert property (@(posedge i_mclk) disable iff (i_srst)
      do_op && w == NCE_OP_ACC_INVERT
      |=> acc_q == ~$past(acc_q) && carry_q == $past(carry_q))
      else $error("accumulator invert wrong");
   a_rotate_right: assert property (@(posedge i_mclk) disable iff (i_srst)
      do_op && w == NCE_OP_ACC_ROTATE_RIGHT
      |=> {acc_q, carry_q} == {$past(carry_q), $past(acc_q)})
      else $error("rotate through carry wrong");
   a_y_inc_skip: assert property (@(posedge i_mclk) disable iff (i_srst)
      do_op && w == NCE_OP_Y_INCREMENT_SKIP
      |=> y_q == $past(y_q) + 4'h1 && skip_q == (y_q == 4'h0))
      else $error("y increment skip wrong");
   a_y_dec_skip: assert property (@(posedge i_mclk) disable iff (i_srst)
      do_op && w == NCE_OP_Y_DECREMENT_SKIP
      |=> y_q == $past(y_q) - 4'h1 && skip_q == (y_q == NCE_Y_MAX))
      else $error("y decrement skip wrong");
   a_acc_ld_run: assert property (@(posedge i_mclk) disable iff (i_srst)
      state_q == NCE_ST_EXEC && is_acc_ld && last_acc_ld_q
      |=> acc_q == $past(acc_q))
      else $error("repeated accumulator load executed");
   a_portd_ones: assert property (@(posedge i_mclk) disable iff (i_srst)
      do_op && w == NCE_OP_PORTD_SET |=> o_port_d == NCE_PORTD_ONES)
      else $error("port d not all ones");
   a_clk_mode_locked: assert property (@(posedge i_mclk) disable iff (i_srst)
      do_op && w == NCE_OP_CLOCK_MODE_ENTRY && !unlock_q && !o_clock_mode
      |=> !o_clock_mode && state_q != NCE_ST_HALT)
      else $error("clock mode entered without unlock");
   a_call_push: assert property (@(posedge i_mclk) disable iff (i_srst)
      state_q == NCE_ST_EXEC2 && !skip2_q
      |=> stack_ptr_q == $past(stack_ptr_q) + 3'h1 &&
          stack_q[stack_ptr_q] == $past(pc_q))
      else $error("call did not push return address");
   a_skip_nop: assert property (@(posedge i_mclk) disable iff (i_srst)
      state_q == NCE_ST_EXEC && skip_q
      |=> $stable(acc_q) && $stable(y_q) && $stable(o_port_d))
      else $error("skipped instruction had an effect");
endmodule

// *** rtl/nce_pkg.sv ***
// constants, opcodes and carrier types of the nibble instruction executor
package nce_pkg;
   localparam int unsigned NCE_PC_W = 13;
   localparam int unsigned NCE_STACK_DEPTH = 8;
   localparam logic [NCE_PC_W-1:0] NCE_PC_RST = 13'h0000;
   localparam logic [3:0] NCE_NIB_RST = 4'h0;
   localparam logic [7:0] NCE_PORTD_RST = 8'h00;
   localparam logic [7:0] NCE_PORTD_ONES = 8'hff;
   localparam logic [3:0] NCE_Y_MAX = 4'hf;
   // apb map
   localparam logic [7:0] NCE_OFS_CTRL = 8'h00;
   localparam logic [7:0] NCE_OFS_STATUS = 8'h04;
   localparam logic [7:0] NCE_OFS_PC = 8'h08;
   localparam int unsigned NCE_CTRL_RUN = 0;
   localparam int unsigned NCE_CTRL_WAKE = 1;
   localparam int unsigned NCE_CTRL_DR_LSB = 4;
   // whole-word opcodes and the port read and write prefixes
   localparam logic [9:0] NCE_OP_NOP = 10'h000;
   localparam logic [9:0] NCE_OP_PORTD_SET = 10'h011;
   localparam logic [9:0] NCE_OP_ACC_INVERT = 10'h01c;
   localparam logic [9:0] NCE_OP_RC_CLOCK_SELECT = 10'h29b;
   localparam logic [9:0] NCE_OP_Y_DECREMENT_SKIP = 10'h017;
   localparam logic [9:0] NCE_OP_Y_INCREMENT_SKIP = 10'h013;
   localparam logic [9:0] NCE_OP_IRQ_DISABLE = 10'h004;
   localparam logic [9:0] NCE_OP_IRQ_ENABLE = 10'h005;
   localparam logic [9:0] NCE_OP_WATCHDOG_STOP_ARM = 10'h29c;
   localparam logic [9:0] NCE_OP_POWERDOWN_UNLOCK = 10'h05b;
   localparam logic [9:0] NCE_OP_CLOCK_MODE_ENTRY = 10'h002;
   localparam logic [9:0] NCE_OP_RAM_BACKUP_ENTRY = 10'h008;
   localparam logic [9:0] NCE_OP_LOGIC_OR = 10'h019;
   localparam logic [9:0] NCE_OP_ACC_ROTATE_RIGHT = 10'h01d;
   localparam logic [7:0] NCE_OP_PORT_READ_HI = 8'h98;
   localparam logic [7:0] NCE_OP_PORT_WRITE_HI = 8'h88;
   localparam logic [9:0] NCE_OP_LONG_INDEXED_CALL = 10'h030;
   // prefix-coded opcodes
   localparam logic [4:0] NCE_OP_LONG_DIRECT_CALL_HI = 5'b00110;
   localparam logic [5:0] NCE_OP_ACC_LOAD_HI = 6'b000111;
   localparam logic [1:0] NCE_OP_XY_LOAD_HI = 2'b11;
   localparam logic [7:0] NCE_OP_Z_LOAD_HI = 8'b00010010;
   localparam logic [7:0] NCE_OP_BIT_CLEAR_HI = 8'b00010011;

   typedef enum logic [2:0] {
      NCE_ST_FETCH = 3'b000,
      NCE_ST_EXEC = 3'b001,
      NCE_ST_FETCH2 = 3'b010,
      NCE_ST_EXEC2 = 3'b011,
      NCE_ST_HALT = 3'b100
   } nce_state_type;

   typedef struct packed {
      logic ram_backup;
      logic clock_mode;
      logic rc_sel;
      logic wdt_arm;
      logic irq_en;
      logic carry;
      logic [2:0] stack_ptr;
      logic [1:0] z;
      logic [3:0] y;
      logic [3:0] x;
      logic [3:0] acc;
   } nce_status_type;
endpackage

// *** test/nce_mem_model.sv ***
// behavioural program and data memory facing the executor
`timescale 1ns/100ps
module nce_mem_model
   import nce_pkg::*;
(
   input wire logic i_mclk,
   input wire logic [nce_pkg::NCE_PC_W-1:0] i_pm_addr,
   output logic [9:0] o_pm_data,
   input wire logic [9:0] i_dm_addr,
   output logic [3:0] o_dm_rdata,
   input wire logic [3:0] i_dm_wdata,
   input wire logic i_dm_we
);
   logic [9:0] pm [0:8191];
   logic [3:0] dm [0:1023];
   // unloaded words stay unknown so stray fetches are not masked
   assign o_pm_data = pm[i_pm_addr];
   assign o_dm_rdata = dm[i_dm_addr];
   // plain always: the bench also preloads dm
   always @(posedge i_mclk)
   begin
      if (i_dm_we)
      begin
         dm[i_dm_addr] <= i_dm_wdata;
      end
   end
endmodule

// *** test/nce_core_tb.sv ***
// self-checking bench for the nibble instruction executor
`timescale 1ns/100ps
module nce_core_tb;
   import nce_pkg::*;
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic psel = 1'b0;
   logic pen = 1'b0;
   logic pwr = 1'b0;
   logic [7:0] padr = 8'h00;
   logic [31:0] pwd = 32'h0;
   logic [3:0] p0 = 4'h0;
   logic [3:0] p1 = 4'h0;
   logic [3:0] p2 = 4'h0;
   logic rdy, err, dmwe, cm, ram_bk;
   logic [31:0] prd;
   logic [NCE_PC_W-1:0] pma;
   logic [9:0] pmd, dma;
   logic [3:0] dmr, dmw, q0, q1, q2, n1, x, m, a;
   logic [1:0] z, j;
   logic [2:0] dr;
   logic [5:0] pg;
   logic [12:0] ta, nx;
   logic [33:0] note;
   logic [33:0] notes [$];
   logic [31:0] rnd = 32'hcad1;
   logic [7:0] pd;
   nce_status_type st;
   int mismatches = 0;
   int samples_checked = 0;

   always #2 clk = ~clk;

   nce_core dut (
      .i_mclk(clk), .i_srst(srst), .i_psel(psel), .i_penable(pen),
      .i_pwrite(pwr), .i_paddr(padr), .i_pwdata(pwd), .o_pready(rdy),
      .o_prdata(prd), .o_pslverr(err), .o_pm_addr(pma), .i_pm_data(pmd),
      .o_dm_addr(dma), .i_dm_rdata(dmr), .o_dm_wdata(dmw), .o_dm_we(dmwe),
      .i_p0(p0), .i_p1(p1), .i_p2(p2), .o_p0(q0), .o_p1(q1), .o_p2(q2),
      .o_port_d(pd), .o_irq_enable(), .o_rc_clock_sel(),
      .o_wdt_stop_armed(), .o_clock_mode(cm), .o_ram_backup(ram_bk)
   );

   nce_mem_model mem (
      .i_mclk(clk), .i_pm_addr(pma), .o_pm_data(pmd), .i_dm_addr(dma),
      .o_dm_rdata(dmr), .i_dm_wdata(dmw), .i_dm_we(dmwe)
   );

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   task automatic check(input string nm, input logic [31:0] seen,
      input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic stop_test();
      $display("checks %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   // one edge passes first so psel never drops and rises in one step
   task automatic apb(input logic wr, input logic [7:0] ad,
      input logic [31:0] wd, input logic [33:0] nt);
      int n;
      n = 0;
      @(posedge clk);
      notes.push_back(nt);
      psel <= 1'b1;
      pwr <= wr;
      padr <= ad;
      pwd <= wd;
      @(posedge clk);
      pen <= 1'b1;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (rdy !== 1'b1 && n < 40);
      psel <= 1'b0;
      pen <= 1'b0;
      if (n >= 40)
      begin
         mismatches++;
         stop_test();
      end
   endtask

   // note layout: {compare data, expected pslverr, expected prdata}
   always @(posedge clk)
   begin
      if (rdy === 1'b1)
      begin
         if (notes.size() == 0)
            check("unexpected answer", 32'h1, 32'h0);
         else
         begin
            note = notes.pop_front();
            check("pslverr", {31'h0, err}, {31'h0, note[32]});
            if (note[33])
               check("prdata", prd, note[31:0]);
         end
      end
   end

   task automatic do_reset();
      @(posedge clk);
      srst <= 1'b1;
      repeat (5) @(posedge clk);
      srst <= 1'b0;
   endtask

   task automatic load(input logic [12:0] at, input logic [9:0] w[$]);
      foreach (w[i])
      begin
         mem.pm[at + 13'(i)] = w[i];
      end
   endtask

   // start the core, wait for a low-power halt, then read state back
   task automatic run_prog(input logic [2:0] d, input logic [31:0] sv,
      input logic [12:0] pc);
      int n;
      n = 0;
      apb(1'b1, NCE_OFS_CTRL, {25'h0, d, 4'h1}, 34'h0);
      while (cm !== 1'b1 && ram_bk !== 1'b1 && n < 2000)
      begin
         @(posedge clk);
         n++;
      end
      if (n >= 2000)
      begin
         mismatches++;
         stop_test();
      end
      apb(1'b0, NCE_OFS_STATUS, 32'h0, {2'b10, sv});
      apb(1'b0, NCE_OFS_PC, 32'h0, {2'b10, 19'h0, pc});
   endtask

   initial
   begin
      do_reset();
      rnd = lfsr(rnd);
      n1 = rnd[3:0];
      load(13'd0, '{{NCE_OP_ACC_LOAD_HI, n1}, {NCE_OP_ACC_LOAD_HI, ~n1},
         NCE_OP_ACC_ROTATE_RIGHT, NCE_OP_ACC_ROTATE_RIGHT, NCE_OP_ACC_INVERT,
         {NCE_OP_PORT_WRITE_HI, 2'd0}, NCE_OP_IRQ_ENABLE, NCE_OP_IRQ_DISABLE,
         NCE_OP_RAM_BACKUP_ENTRY, NCE_OP_PORTD_SET, NCE_OP_RC_CLOCK_SELECT,
         NCE_OP_WATCHDOG_STOP_ARM, NCE_OP_POWERDOWN_UNLOCK, NCE_OP_NOP,
         NCE_OP_CLOCK_MODE_ENTRY, NCE_OP_POWERDOWN_UNLOCK,
         NCE_OP_CLOCK_MODE_ENTRY});
      st = '0;
      st.acc = ~{n1[0], 1'b0, n1[3:2]};
      st.carry = n1[1];
      st.rc_sel = 1'b1;
      st.wdt_arm = 1'b1;
      st.clock_mode = 1'b1;
      run_prog(3'd0, {9'h0, st}, 13'd17);
      check("port d", {24'h0, pd}, {24'h0, NCE_PORTD_ONES});
      check("port 0", {28'h0, q0}, {28'h0, st.acc});
      $display("accumulator test done");

      do_reset();
      rnd = lfsr(rnd);
      x = rnd[7:4];
      z = rnd[9:8];
      j = rnd[11:10];
      m = rnd[27:24];
      p0 <= rnd[15:12];
      p1 <= rnd[19:16];
      p2 <= rnd[23:20];
      mem.dm[{z, x, 4'hf}] = m;
      load(13'd0, '{{NCE_OP_XY_LOAD_HI, x, 4'hf}, {NCE_OP_XY_LOAD_HI, 8'h00},
         NCE_OP_Y_INCREMENT_SKIP, {NCE_OP_ACC_LOAD_HI, 4'h9},
         NCE_OP_Y_DECREMENT_SKIP, {NCE_OP_Z_LOAD_HI, ~z},
         {NCE_OP_Z_LOAD_HI, z}, {NCE_OP_PORT_READ_HI, 2'd1}, NCE_OP_LOGIC_OR,
         {NCE_OP_BIT_CLEAR_HI, j}, {NCE_OP_PORT_WRITE_HI, 2'd2},
         {NCE_OP_PORT_READ_HI, 2'd0}, {NCE_OP_PORT_WRITE_HI, 2'd1},
         {NCE_OP_PORT_READ_HI, 2'd2}, NCE_OP_IRQ_ENABLE, NCE_OP_NOP,
         NCE_OP_POWERDOWN_UNLOCK, NCE_OP_RAM_BACKUP_ENTRY});
      st = '0;
      st.x = x;
      st.y = 4'hf;
      st.z = z;
      st.acc = rnd[23:20];
      st.irq_en = 1'b1;
      st.ram_backup = 1'b1;
      run_prog(rnd[30:28], {9'h0, st}, 13'd18);
      check("port 2", {28'h0, q2}, {28'h0, rnd[19:16] | m});
      check("port 1", {28'h0, q1}, {28'h0, rnd[15:12]});
      m = m & ~(4'h1 << j);
      check("nibble", {28'h0, mem.dm[{z, x, 4'hf}]}, {28'h0, m});
      apb(1'b0, 8'h0c, 32'h0, {2'b11, 32'h0});
      apb(1'b1, NCE_OFS_STATUS, 32'hffffffff, 34'h0);
      apb(1'b0, NCE_OFS_STATUS, 32'h0, {2'b10, 9'h0, st});
      $display("index and memory test done");

      do_reset();
      rnd = lfsr(rnd);
      a = rnd[3:0];
      dr = rnd[6:4];
      pg = {1'b1, rnd[11:7]};
      load(13'd0, '{{NCE_OP_ACC_LOAD_HI, a}, NCE_OP_LONG_INDEXED_CALL,
         {2'b10, pg[5:4], 2'b00, pg[3:0]}});
      ta = {pg, dr, a};
      // nine pushes in all, one past the eight-level stack
      for (int k = 1; k <= 8; k++)
      begin
         nx = {6'h02, 7'(8 * k)};
         load(ta, '{{NCE_OP_LONG_DIRECT_CALL_HI, nx[11:7]},
            {2'b10, nx[12], nx[6:0]}});
         ta = nx;
      end
      load(ta, '{NCE_OP_POWERDOWN_UNLOCK, NCE_OP_CLOCK_MODE_ENTRY});
      st = '0;
      st.acc = a;
      st.stack_ptr = 3'd1;
      st.clock_mode = 1'b1;
      run_prog(dr, {9'h0, st}, ta + 13'd2);
      $display("call test done");

      repeat (3) @(posedge clk);
      check("open answers", 32'(notes.size()), 32'h0);
      stop_test();
   end
endmodule
